// *** inc/swrs_consts.svh ***
// Timing and command constants for the single-wire selection block
`ifndef SWRS_CONSTS_SVH
`define SWRS_CONSTS_SVH

// ----------------------------------------
// Clock and slot timing
// ----------------------------------------
`define SWRS_CLK_NS 20
`define SWRS_SAMPLE_NS 200
`define SWRS_SAMPLE_CYC ((`SWRS_SAMPLE_NS + `SWRS_CLK_NS - 1) / `SWRS_CLK_NS)
`define SWRS_HOLD0_NS 600
`define SWRS_HOLD0_CYC (`SWRS_HOLD0_NS / `SWRS_CLK_NS)
`define SWRS_RESET_NS 48000
`define SWRS_RESET_CYC ((`SWRS_RESET_NS + `SWRS_CLK_NS - 1) / `SWRS_CLK_NS)
`define SWRS_PRES_WAIT_NS 2000
`define SWRS_PRES_WAIT_CYC ((`SWRS_PRES_WAIT_NS + `SWRS_CLK_NS - 1) / `SWRS_CLK_NS)
`define SWRS_PRES_LEN_NS 8000
`define SWRS_PRES_LEN_CYC ((`SWRS_PRES_LEN_NS + `SWRS_CLK_NS - 1) / `SWRS_CLK_NS)
`define SWRS_TMR_W 12

// ----------------------------------------
// Selection command codes
// ----------------------------------------
`define SWRS_CMD_SEARCH 8'hF0
`define SWRS_CMD_READ_ID 8'h33
`define SWRS_CMD_MATCH 8'h55
`define SWRS_CMD_SKIP 8'hCC
`define SWRS_CMD_RESUME 8'hA5
`define SWRS_ID_LAST 6'h3F
`define SWRS_CMD_LAST 3'h7

`endif

// *** inc/swrs_pkg.sv ***
// Types for the single-wire selection block
package swrs_pkg;
   typedef enum logic [2:0] {
      SWRS_WAIT_CMD,
      SWRS_SEND_ID,
      SWRS_SEARCH,
      SWRS_MATCH,
      SWRS_FUNCTION,
      SWRS_IGNORE
   } swrs_state_e;
endpackage : swrs_pkg

// *** hdl/swrs_select.sv ***
// Slave bit-slot engine and selection command handling for a single-wire bus
// Functional notes
// RULE_01: Master opens a read slot like a write-one slot.
// RULE_02: Device sends 0 by pulling low until its timer ends; 1 leaves line free.
// RULE_03: Master samples late inside the sampling window, read low time short.
// RULE_04: Master waits full slot period before next slot, giving recovery.
// RULE_05: Several devices: master lengthens recovery or drives high actively.
// RULE_06: After presence, take an 8-bit command; five codes recognised.
// RULE_07: Search per bit LSB first: send true, send complement, read master's choice.
// RULE_08: Search drops out when master's bit differs from own identifier bit.
// RULE_09: Master treats both reads zero as conflict and picks branch.
// RULE_10: Read identifier sends family code, 48-bit serial, check byte.
// RULE_11: Master uses read identifier only with a single slave.
// RULE_12: Match selects only if all 64 bits match, else idle until reset.
// RULE_13: Skip goes straight to function handling.
// RULE_14: Resume with flag set goes to function handling like skip.
// RULE_15: Flag set only by successful match or search selecting this device.
// RULE_16: Flag cleared when another device is selected.
// RULE_17: Transaction: reset, presence, selection, function command, data.
// RULE_18: Master keeps write-zero low long enough, releases write-one early.
// RULE_19: Slot timer restarts at each falling edge; sets sample and hold times.
// RULE_20: Bytes and identifier travel LSB first, one bit per slot.
// RULE_21: Unknown code or resume with clear flag: ignore slots until reset.
// RULE_22: Reset pulse aborts everything; resume flag survives reset.
module swrs_select (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [63:0] rom_id,
   input wire logic line_in,
   output logic line_out,
   output logic line_oe,
   output logic selected,
   output logic function_bit_valid,
   output logic function_bit
);
`include "swrs_consts.svh"

   // ----------------------------------------
   // Line input synchroniser and edge detect
   // ----------------------------------------
   logic line_meta;
   logic line_sync;
   logic line_prev;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
         line_prev <= 1'b1;
      end else begin
         line_meta <= line_in;
         line_sync <= line_meta;
         line_prev <= line_sync;
      end
   end
   wire fall = line_prev & ~line_sync;
   wire rise = ~line_prev & line_sync;

   // ----------------------------------------
   // Slot timer, low-time counter, presence
   // ----------------------------------------
   // Timer saturates so a long idle line never wraps into a false sample
   logic [`SWRS_TMR_W-1:0] slot_tmr;
   logic [`SWRS_TMR_W-1:0] low_tmr;
   logic [`SWRS_TMR_W-1:0] pres_tmr;
   logic pres_active;
   logic reset_seen;
   wire tmr_max = &slot_tmr;
   wire sample_now = (slot_tmr == `SWRS_TMR_W'(`SWRS_SAMPLE_CYC)) & ~pres_active;
   wire reset_pulse = rise & (low_tmr >= `SWRS_TMR_W'(`SWRS_RESET_CYC));
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         slot_tmr <= '1;
         low_tmr <= 12'h000;
      end else begin
         slot_tmr <= fall ? 12'h000 : (tmr_max ? slot_tmr : slot_tmr + 12'h001); // RULE_19
         low_tmr <= line_sync ? 12'h000 : (&low_tmr ? low_tmr : low_tmr + 12'h001);
      end
   end

   // Presence pulse after the reset pulse, before selection begins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pres_tmr <= 12'h000;
         pres_active <= 1'b0;
         reset_seen <= 1'b0;
      end else if (reset_pulse) begin
         pres_tmr <= 12'h000;
         pres_active <= 1'b1; // RULE_17
         reset_seen <= 1'b1;
      end else if (pres_active) begin
         pres_tmr <= pres_tmr + 12'h001;
         if (pres_tmr == `SWRS_TMR_W'(`SWRS_PRES_WAIT_CYC + `SWRS_PRES_LEN_CYC))
            pres_active <= 1'b0;
      end
   end
   wire pres_drive = pres_active & (pres_tmr >= `SWRS_TMR_W'(`SWRS_PRES_WAIT_CYC));

   // ----------------------------------------
   // Selection state machine
   // ----------------------------------------
   swrs_pkg::swrs_state_e state;
   logic [7:0] cmd;
   logic [2:0] cmd_cnt;
   logic [5:0] bit_idx;
   logic [1:0] phase;
   logic id_ok;
   logic resume_select_flag;
   logic tx_bit;
   wire own_bit = rom_id[bit_idx];
   wire [7:0] next_cmd = {line_sync, cmd[7:1]}; // RULE_20
   wire last_id = (bit_idx == `SWRS_ID_LAST);
   wire bit_match = (line_sync == own_bit);

   // Drive value for the coming slot: true bit, then complement in search
   always_comb begin
      tx_bit = 1'b1;
      case (state)
         swrs_pkg::SWRS_SEND_ID: tx_bit = own_bit; // RULE_10
         swrs_pkg::SWRS_SEARCH: tx_bit = (phase == 2'h0) ? own_bit : ((phase == 2'h1) ? ~own_bit : 1'b1); // RULE_07
         default: tx_bit = 1'b1;
      endcase
   end

   // Selection steps advance once per slot, at the sample point of the slot timer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= swrs_pkg::SWRS_IGNORE;
         cmd <= 8'h00;
         cmd_cnt <= 3'h0;
         bit_idx <= 6'h00;
         phase <= 2'h0;
         id_ok <= 1'b1;
         resume_select_flag <= 1'b0;
      end else if (reset_pulse) begin
         state <= swrs_pkg::SWRS_WAIT_CMD; // RULE_22
         cmd_cnt <= 3'h0;
         bit_idx <= 6'h00;
         phase <= 2'h0;
         id_ok <= 1'b1;
      end else if (sample_now & reset_seen) begin
         case (state)
            swrs_pkg::SWRS_WAIT_CMD: begin
               cmd <= next_cmd;
               cmd_cnt <= cmd_cnt + 3'h1;
               if (cmd_cnt == `SWRS_CMD_LAST) begin
                  case (next_cmd) // RULE_06
                     `SWRS_CMD_SEARCH: state <= swrs_pkg::SWRS_SEARCH;
                     `SWRS_CMD_READ_ID: state <= swrs_pkg::SWRS_SEND_ID;
                     `SWRS_CMD_MATCH: state <= swrs_pkg::SWRS_MATCH;
                     `SWRS_CMD_SKIP: state <= swrs_pkg::SWRS_FUNCTION; // RULE_13
                     `SWRS_CMD_RESUME: state <= resume_select_flag ? swrs_pkg::SWRS_FUNCTION // RULE_14
                                                                   : swrs_pkg::SWRS_IGNORE; // RULE_21
                     default: state <= swrs_pkg::SWRS_IGNORE; // RULE_21
                  endcase
               end
            end
            swrs_pkg::SWRS_SEND_ID: begin
               bit_idx <= bit_idx + 6'h01;
               if (last_id)
                  state <= swrs_pkg::SWRS_FUNCTION;
            end
            swrs_pkg::SWRS_SEARCH: begin
               if (phase == 2'h2) begin
                  phase <= 2'h0;
                  bit_idx <= bit_idx + 6'h01;
                  if (!bit_match) begin
                     state <= swrs_pkg::SWRS_IGNORE; // RULE_08
                     resume_select_flag <= 1'b0; // RULE_16
                  end else if (last_id) begin
                     state <= swrs_pkg::SWRS_FUNCTION;
                     resume_select_flag <= 1'b1; // RULE_15
                  end
               end else begin
                  phase <= phase + 2'h1;
               end
            end
            swrs_pkg::SWRS_MATCH: begin
               bit_idx <= bit_idx + 6'h01;
               if (last_id) begin
                  state <= (id_ok & bit_match) ? swrs_pkg::SWRS_FUNCTION : swrs_pkg::SWRS_IGNORE; // RULE_12
                  resume_select_flag <= id_ok & bit_match; // RULE_15
               end else begin
                  id_ok <= id_ok & bit_match;
               end
            end
            default: state <= state;
         endcase
      end
   end

   // ----------------------------------------
   // Read-slot pull-down and function bit stream
   // ----------------------------------------
   // Only a zero is driven; a one leaves the line to the pull-up
   // Release comes from the slot timer, so a slow rise on the line cannot stretch the pull
   logic drive0;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         drive0 <= 1'b0;
      end else if (fall & ~pres_active & ~tx_bit) begin
         drive0 <= 1'b1; // RULE_02
      end else if (slot_tmr == `SWRS_TMR_W'(`SWRS_HOLD0_CYC)) begin
         drive0 <= 1'b0; // RULE_02
      end
   end

   // Function-phase bits leave one per slot, registered at the sample edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         function_bit_valid <= 1'b0;
         function_bit <= 1'b0;
      end else begin
         function_bit_valid <= sample_now & (state == swrs_pkg::SWRS_FUNCTION) & ~reset_pulse;
         function_bit <= line_sync;
      end
   end

   assign line_oe = drive0 | pres_drive;
   assign line_out = 1'b0;
   assign selected = (state == swrs_pkg::SWRS_FUNCTION);
endmodule : swrs_select

// *** bench/swrs_select_chk.sv ***
// Port-level protocol checker for the single-wire selection block
module swrs_select_chk (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [63:0] rom_id,
   input wire logic line_in,
   input wire logic line_out,
   input wire logic line_oe,
   input wire logic selected,
   input wire logic function_bit_valid,
   input wire logic function_bit
);
   logic [9:0] oe_cnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Length of the current pull-down; presence is the longest one
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         oe_cnt <= 10'h000;
      end else begin
         oe_cnt <= line_oe ? oe_cnt + 10'h001 : 10'h000;
      end
   end
   a_drive_never_high: assert property (line_out == 1'b0) else $error("line driven high");
   a_reset_quiet: assert property (disable iff (1'b0) rst |-> !line_oe && !selected && !function_bit_valid)
      else $error("outputs active in reset");
   a_valid_one_cycle: assert property (function_bit_valid |=> !function_bit_valid) else $error("long valid");
   a_valid_when_sel: assert property (function_bit_valid |-> selected) else $error("bit outside function");
   a_zero_min_hold: assert property ($rose(line_oe) |-> line_oe [*8]) else $error("short pull");
   a_pull_max_len: assert property (oe_cnt <= 10'h19A) else $error("pull too long");
   a_sel_no_drive: assert property ($rose(line_oe) |-> !selected) else $error("pull started while selected");
   a_sel_kept: assert property ($fell(selected) |-> $past(line_in, 8) == 1'b0) else $error("lost select");
endmodule : swrs_select_chk

bind swrs_select swrs_select_chk u_chk (.sys_clk(sys_clk), .rst(rst), .rom_id(rom_id), .line_in(line_in),
   .line_out(line_out), .line_oe(line_oe), .selected(selected), .function_bit_valid(function_bit_valid),
   .function_bit(function_bit));

// *** bench/swrs_master.sv ***
// Bus master model: reset pulse and bit slots on the open-drain line
module swrs_master (
   input wire logic sys_clk,
   input wire logic line,
   output logic mlow
);
   timeunit 1ns;
   timeprecision 1ps;
   initial mlow = 1'b0;
   // One slot; low time kept past the device's own pull-down start
   task automatic slot(input logic wb, output logic rb);
      @(negedge sys_clk) mlow = 1'b1;
      repeat (6) @(negedge sys_clk);
      mlow = !wb;
      repeat (4) @(negedge sys_clk);
      rb = line;
      repeat (19) @(negedge sys_clk);
      mlow = 1'b0;
      repeat (30) @(negedge sys_clk);
   endtask : slot
   // Reset pulse, then look for presence mid-window
   task automatic bus_reset(output logic pres);
      @(negedge sys_clk) mlow = 1'b1;
      repeat (2450) @(negedge sys_clk);
      mlow = 1'b0;
      repeat (300) @(negedge sys_clk);
      pres = !line;
      repeat (300) @(negedge sys_clk);
   endtask : bus_reset
endmodule : swrs_master

// *** bench/tb_top.sv ***
// Self-checking bench for the single-wire selection block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b0;
   logic [63:0] rom_id;
   logic mlow, line_out, line_oe, selected, function_bit_valid, function_bit, t, c;
   logic [63:0] v;
   logic exp_q[$];
   logic fn_exp = 1'b0;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int rc;
   int j;
   // Pull-up line: low while either party pulls
   wire line = !(mlow || line_oe);
   swrs_select u_dut (.sys_clk(sys_clk), .rst(rst), .rom_id(rom_id), .line_in(line), .line_out(line_out),
      .line_oe(line_oe), .selected(selected), .function_bit_valid(function_bit_valid), .function_bit(function_bit));
   swrs_master u_mst (.sys_clk(sys_clk), .line(line), .mlow(mlow));
   initial forever #10 sys_clk = !sys_clk;
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic wr8(input logic [7:0] val);
      for (int i = 0; i < 8; i++) u_mst.slot(val[i], t);
   endtask : wr8
   task automatic io64(input logic [63:0] val, output logic [63:0] r);
      for (int i = 0; i < 64; i++) u_mst.slot(val[i], r[i]);
   endtask : io64
   task automatic sel(input logic [7:0] cmd);
      // The opening low of a bus reset is a slot to a selected device: it reads a zero
      if (fn_exp) exp_q.push_back(1'b0);
      u_mst.bus_reset(c);
      chk("presence", 1'b1, c);
      chk("reset_left", 0, exp_q.size());
      wr8(cmd);
   endtask : sel
   // Queue a random byte, then write it in the function phase
   task automatic fn;
      v = 64'($urandom);
      for (int i = 0; i < 8; i++) exp_q.push_back(v[i]);
      wr8(v[7:0]);
      chk("fn_left", 0, exp_q.size());
   endtask : fn
   task automatic done(input string s);
      $display("test %s done, errors %0d", s, num_errors);
   endtask : done
   // Sampled function bits against the queue; hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (function_bit_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("extra_bit", 0, 1);
         else chk("function_bit", exp_q.pop_front(), function_bit);
      end
      if (cyc == 95000) begin
         num_errors++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(32'h3FE1B484));
      rom_id = {$urandom, $urandom};
      // Raised after time zero so the asynchronous reset branches see an edge
      #1 rst = 1'b1;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      sel(8'hCC);
      chk("skip_sel", 1'b1, selected);
      fn_exp = 1'b1;
      fn();
      done("skip");
      sel(8'h33);
      io64(64'hFFFF_FFFF_FFFF_FFFF, v);
      chk("read_id", rom_id, v);
      chk("read_sel", 1'b1, selected);
      fn_exp = 1'b1;
      done("read_id");
      // Own identifier, then one flipped bit; resume follows the flag
      for (int k = 0; k < 2; k++) begin
         sel(8'h55);
         io64(rom_id ^ 64'(k), v);
         rc = (k == 0);
         chk("match_sel", rc, selected);
         fn_exp = 1'(rc);
         sel(8'hA5);
         chk("resume_sel", rc, selected);
         if (k == 0) fn();
         done("match");
      end
      // Full pass selects; a wrong choice at a random bit drops out
      for (int k = 0; k < 2; k++) begin
         sel(8'hF0);
         j = k ? $urandom_range(63) : 64;
         for (int i = 0; i < 64; i++) begin
            u_mst.slot(1'b1, t);
            u_mst.slot(1'b1, c);
            chk("search_pair", i > j ? 2'b11 : {!rom_id[i], rom_id[i]}, {c, t});
            u_mst.slot(rom_id[i] ^ (i == j), t);
         end
         rc = (k == 0);
         chk("search_sel", rc, selected);
         fn_exp = 1'(rc);
         sel(8'hA5);
         chk("resume_after", rc, selected);
         done("search");
      end
      sel(8'h00);
      io64(64'hFFFF_FFFF_FFFF_FFFF, v);
      chk("ignored_read", 64'hFFFF_FFFF_FFFF_FFFF, v);
      chk("ignored_sel", 1'b0, selected);
      done("unknown");
      stop_test();
   end
endmodule : tb_top
